// ===== src/embedded_memory_block.sv
// Configurable embedded memory block: port control, configuration and status.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - Quad mode takes two reads, two writes.
// - Inputs registered; optional output pipeline register.
// - True dual: any two port operations.
// - Dual mode: one read, one write together.
// - Single port: read and write never together.
// - Each port width chosen independently.
// - Internal write strobe timed from clock.
// - Quad/true dual shapes up to 256x16.
// - Dual/single also allow 128x32.
// - Splits into two independent 2048-bit halves.
// - Read/write or input/output clock scheme.
// - Read/write scheme: write and read events.
// - Input/output scheme: input and output events.
// - Per-port clock enables and clear.
// - Dual-port function uses one port half.
// - Port pipeline registers clearable by clear or reset; config and status by reset, collision bits also by a status write.
module embedded_memory_block (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_bus_addr,
    input wire logic [31:0] i_bus_wdata,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    output logic [31:0] o_bus_rdata,
    input wire logic [1:0] i_wclk,
    input wire logic [1:0] i_rclk,
    input wire logic [1:0] i_oclk,
    input wire logic [1:0] i_wce,
    input wire logic [1:0] i_rce,
    input wire logic [1:0] i_clr,
    input wire logic [1:0] i_we,
    input wire logic [1:0][11:0] i_waddr,
    input wire logic [1:0][31:0] i_wdata,
    input wire logic [1:0] i_read_strobe,
    input wire logic [1:0][11:0] i_raddr,
    output logic [1:0][31:0] o_rdata,
    output logic [1:0] o_rvalid
);
    ram_port_if st ();

    logic [31:0] cfg_q;
    logic [31:0] width_q;
    logic [1:0] coll_q;
    logic illegal_q;
    logic [1:0] wgo_q;
    logic [1:0][11:0] waddr_q;
    logic [1:0][31:0] wdata_q;
    logic [1:0] rgo_q;
    logic [1:0][11:0] raddr_q;
    logic [1:0][31:0] stage_q;
    logic [1:0] stage_v_q;
    logic [1:0][31:0] rdata_q;
    logic [1:0] rvalid_q;
    logic [31:0] bus_rdata_q;

    ram_block_pkg::mode_type mode_a;
    ram_block_pkg::mode_type mode_b;
    ram_block_pkg::mode_type pmode [2];
    logic split;
    logic ioclk;
    logic [1:0] outreg;
    logic [1:0][2:0] wcode;
    logic [1:0][2:0] rcode;
    logic [1:0] act;
    logic [1:0] excl;
    logic [1:0] wreq;
    logic [1:0] rreq;
    logic [1:0] otick;
    logic [1:0] wr_take;
    logic [1:0] rd_take;
    logic has_max;
    logic has_min;

    assign mode_a = ram_block_pkg::mode_type'(cfg_q[ram_block_pkg::CFG_MODE_A_LSB +: 2]);
    assign mode_b = ram_block_pkg::mode_type'(cfg_q[ram_block_pkg::CFG_MODE_B_LSB +: 2]);
    assign split = cfg_q[ram_block_pkg::CFG_SPLIT_BIT];
    assign ioclk = cfg_q[ram_block_pkg::CFG_IOCLK_BIT];
    assign outreg = cfg_q[ram_block_pkg::CFG_OUTREG_LSB +: 2];

    always_comb
    begin
        has_max = 1'b0;
        has_min = 1'b0;
        for (int p = 0; p < 2; p++)
        begin
            wcode[p] = width_q[p * ram_block_pkg::WIDTH_STRIDE +: 3];
            rcode[p] = width_q[p * ram_block_pkg::WIDTH_STRIDE + ram_block_pkg::RCODE_OFS +: 3];
            // With halves split, each half runs as its own dual or single RAM.
            pmode[p] = (p == 1 && split) ? mode_b : mode_a;
            act[p] = (p == 0) || split || mode_a == ram_block_pkg::MODE_QUAD
                || mode_a == ram_block_pkg::MODE_TRUE_DUAL;
            excl[p] = pmode[p] == ram_block_pkg::MODE_SINGLE
                || (!split && pmode[p] == ram_block_pkg::MODE_TRUE_DUAL);
            wreq[p] = i_wclk[p] && i_wce[p] && i_we[p] && !i_clr[p];
            // The input event also captures the read address in the I/O scheme.
            rreq[p] = (ioclk ? (i_wclk[p] && i_wce[p]) : (i_rclk[p] && i_rce[p]))
                && i_read_strobe[p] && !i_clr[p];
            otick[p] = (ioclk ? i_oclk[p] : i_rclk[p]) && i_rce[p];
            wr_take[p] = act[p] && wreq[p];
            rd_take[p] = act[p] && rreq[p] && !(excl[p] && wreq[p]);
            has_max = has_max || wcode[p] == ram_block_pkg::CODE_MAX
                || rcode[p] == ram_block_pkg::CODE_MAX;
            has_min = has_min || wcode[p] == ram_block_pkg::CODE_X1
                || rcode[p] == ram_block_pkg::CODE_X1;
        end
    end

    // Shape check only flags; the store still follows whatever is programmed.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            illegal_q <= 1'b0;
        end
        else
        begin
            illegal_q <= (has_max && has_min)
                || wcode[0] > ram_block_pkg::CODE_MAX || rcode[0] > ram_block_pkg::CODE_MAX
                || wcode[1] > ram_block_pkg::CODE_MAX || rcode[1] > ram_block_pkg::CODE_MAX
                || (has_max && !split && (mode_a == ram_block_pkg::MODE_QUAD
                || mode_a == ram_block_pkg::MODE_TRUE_DUAL))
                || (split && (mode_a < ram_block_pkg::MODE_DUAL
                || mode_b < ram_block_pkg::MODE_DUAL));
        end
    end

    // Write side: capture, then the next edge writes the store by itself.
    always_ff @(posedge i_sys_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (!i_nrst || i_clr[p])
            begin
                wgo_q[p] <= 1'b0;
                waddr_q[p] <= 12'h000;
                wdata_q[p] <= 32'h0000_0000;
            end
            else
            begin
                wgo_q[p] <= wr_take[p];
                if (wr_take[p])
                begin
                    waddr_q[p] <= i_waddr[p];
                    wdata_q[p] <= i_wdata[p];
                end
            end
        end
    end

    // Read side: address capture, optional stage, output flop.
    always_ff @(posedge i_sys_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (!i_nrst || i_clr[p])
            begin
                rgo_q[p] <= 1'b0;
                raddr_q[p] <= 12'h000;
                stage_q[p] <= 32'h0000_0000;
                stage_v_q[p] <= 1'b0;
                rdata_q[p] <= 32'h0000_0000;
                rvalid_q[p] <= 1'b0;
            end
            else
            begin
                rgo_q[p] <= rd_take[p];
                if (rd_take[p])
                begin
                    raddr_q[p] <= i_raddr[p];
                end
                rvalid_q[p] <= 1'b0;
                if (otick[p] && stage_v_q[p])
                begin
                    rdata_q[p] <= stage_q[p];
                    rvalid_q[p] <= 1'b1;
                    stage_v_q[p] <= 1'b0;
                end
                // A newer read overwrites a staged word that was never emitted.
                if (rgo_q[p] && outreg[p])
                begin
                    stage_q[p] <= st.rdata[p];
                    stage_v_q[p] <= 1'b1;
                end
                else if (rgo_q[p])
                begin
                    rdata_q[p] <= st.rdata[p];
                    rvalid_q[p] <= 1'b1;
                end
            end
        end
    end

    assign st.wr_go = wgo_q;
    assign st.waddr = waddr_q;
    assign st.wdata = wdata_q;
    assign st.wcode = wcode;
    assign st.raddr = raddr_q;
    assign st.rcode = rcode;
    assign st.split = split;

    mem_bit_store u_store (
        .i_sys_clk(i_sys_clk),
        .port(st)
    );

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            cfg_q <= ram_block_pkg::CFG_RESET;
            width_q <= ram_block_pkg::WIDTH_RESET;
        end
        else if (i_bus_wr && i_bus_addr == ram_block_pkg::REG_CFG)
        begin
            cfg_q <= i_bus_wdata;
        end
        else if (i_bus_wr && i_bus_addr == ram_block_pkg::REG_WIDTH)
        begin
            width_q <= i_bus_wdata;
        end
    end

    // A collision in the same cycle as its clear is kept.
    always_ff @(posedge i_sys_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (!i_nrst)
            begin
                coll_q[p] <= 1'b0;
            end
            else if (act[p] && excl[p] && wreq[p] && rreq[p])
            begin
                coll_q[p] <= 1'b1;
            end
            else if (i_bus_wr && i_bus_addr == ram_block_pkg::REG_STATUS
                && i_bus_wdata[ram_block_pkg::STAT_COLL_LSB + p])
            begin
                coll_q[p] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            bus_rdata_q <= 32'h0000_0000;
        end
        else if (i_bus_rd)
        begin
            case (i_bus_addr)
                ram_block_pkg::REG_CFG: bus_rdata_q <= cfg_q;
                ram_block_pkg::REG_WIDTH: bus_rdata_q <= width_q;
                ram_block_pkg::REG_STATUS: bus_rdata_q <= {29'h0, coll_q, illegal_q};
                default: bus_rdata_q <= 32'h0000_0000;
            endcase
        end
        else
        begin
            bus_rdata_q <= 32'h0000_0000;
        end
    end

    assign o_bus_rdata = bus_rdata_q;
    assign o_rdata = rdata_q;
    assign o_rvalid = rvalid_q;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    property p_quad_four;
        !split && mode_a == ram_block_pkg::MODE_QUAD && wreq == 2'h3 && rreq == 2'h3
            |=> wgo_q == 2'h3 && rgo_q == 2'h3;
    endproperty
    a_quad_four: assert property (p_quad_four) else $error("quad ops lost");

    property p_bypass_lat;
        rd_take[0] && !outreg[0] && !i_bus_wr ##1 !i_clr[0] |=> rvalid_q[0];
    endproperty
    a_bypass_lat: assert property (p_bypass_lat) else $error("bypass read late");

    property p_true_two_writes;
        !split && mode_a == ram_block_pkg::MODE_TRUE_DUAL && wreq == 2'h3 |=> wgo_q == 2'h3;
    endproperty
    a_true_two_writes: assert property (p_true_two_writes) else $error("true dual write lost");

    property p_dual_rw;
        !split && mode_a == ram_block_pkg::MODE_DUAL && wreq[0] && rreq[0]
            |=> wgo_q[0] && rgo_q[0];
    endproperty
    a_dual_rw: assert property (p_dual_rw) else $error("dual read or write lost");

    property p_single_excl;
        pmode[0] == ram_block_pkg::MODE_SINGLE && wreq[0] |=> !rgo_q[0];
    endproperty
    a_single_excl: assert property (p_single_excl) else $error("single port overlap");

    property p_wr_strobe;
        wgo_q[0] |-> $past(wr_take[0]);
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("stray write strobe");

    property p_ioclk_read;
        ioclk && i_rclk[0] && !i_wclk[0] |-> !rd_take[0];
    endproperty
    a_ioclk_read: assert property (p_ioclk_read) else $error("read event in io scheme");

    property p_clear;
        i_clr[0] |=> !wgo_q[0] && !rgo_q[0] && !rvalid_q[0] && !stage_v_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");

    property p_one_half;
        !split && mode_a == ram_block_pkg::MODE_DUAL |=> !wgo_q[1] && !rgo_q[1];
    endproperty
    a_one_half: assert property (p_one_half) else $error("second half used");

    property p_outreg;
        stage_v_q[0] && otick[0] && !i_clr[0] |=> rvalid_q[0] && rdata_q[0] == $past(stage_q[0]);
    endproperty
    a_outreg: assert property (p_outreg) else $error("output stage not moved");

    property p_ratio_flag;
        has_max && has_min |=> illegal_q;
    endproperty
    a_ratio_flag: assert property (p_ratio_flag) else $error("width ratio not flagged");

    c_quad: cover property (mode_a == ram_block_pkg::MODE_QUAD && wgo_q == 2'h3 && rgo_q == 2'h3);
    c_split: cover property (split && wgo_q[1] && rvalid_q[0]);
    c_outreg: cover property (outreg[0] && rvalid_q[0]);
    c_coll: cover property (coll_q[0]);
    c_dual_rw: cover property (pmode[0] == ram_block_pkg::MODE_DUAL && wgo_q[0] && rgo_q[0]);

endmodule : embedded_memory_block
`default_nettype wire

// ===== src/mem_bit_store.sv
// The 4096 storage bits with two write and two read paths of any width.
`timescale 1ns/1ps
`default_nettype none
module mem_bit_store (
    input wire logic i_sys_clk,
    ram_port_if.store port
);
    logic [4095:0] bits_q;

    // Port B is written first so that port A wins a same-bit clash.
    always_ff @(posedge i_sys_clk)
    begin
        for (int p = 1; p >= 0; p--)
        begin
            if (port.wr_go[p])
            begin
                for (int i = 0; i < 32; i++)
                begin
                    if (6'(i) < ram_block_pkg::sub_width(port.wcode[p]))
                    begin
                        bits_q[ram_block_pkg::bit_base(port.waddr[p], port.wcode[p],
                            port.split, 1'(p)) + 12'(i)] <= port.wdata[p][i];
                    end
                end
            end
        end
    end

    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 32; i++)
            begin
                if (6'(i) < ram_block_pkg::sub_width(port.rcode[p]))
                begin
                    port.rdata[p][i] = bits_q[ram_block_pkg::bit_base(port.raddr[p],
                        port.rcode[p], port.split, 1'(p)) + 12'(i)];
                end
                else
                begin
                    port.rdata[p][i] = 1'b0;
                end
            end
        end
    end

endmodule : mem_bit_store
`default_nettype wire

// ===== src/ram_block_pkg.sv
// Constants, field layout and helpers shared by the embedded memory block.
package ram_block_pkg;

    localparam int unsigned TOTAL_BITS = 4096;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CODE_W = 3;
    localparam int unsigned BUS_AW = 4;

    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_WIDTH = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] WIDTH_RESET = 32'h0000_0000;

    localparam int unsigned CFG_MODE_A_LSB = 0;
    localparam int unsigned CFG_MODE_B_LSB = 2;
    localparam int unsigned CFG_SPLIT_BIT = 4;
    localparam int unsigned CFG_IOCLK_BIT = 5;
    localparam int unsigned CFG_OUTREG_LSB = 6;

    localparam int unsigned WIDTH_STRIDE = 8;
    localparam int unsigned RCODE_OFS = 4;

    localparam int unsigned STAT_ILLEGAL_BIT = 0;
    localparam int unsigned STAT_COLL_LSB = 1;

    localparam logic [2:0] CODE_X1 = 3'h0;
    localparam logic [2:0] CODE_MAX_QUAD = 3'h4;
    localparam logic [2:0] CODE_MAX = 3'h5;

    typedef enum logic [1:0] {MODE_QUAD, MODE_TRUE_DUAL, MODE_DUAL, MODE_SINGLE} mode_type;

    // Number of bits a port moves per access for a width code.
    function automatic logic [5:0] sub_width(input logic [2:0] code);
        return 6'h01 << code;
    endfunction : sub_width

    // First bit of the addressed sub-word; lowest address holds the low bits.
    function automatic logic [11:0] bit_base(input logic [11:0] addr, input logic [2:0] code,
        input logic split, input logic half);
        logic [12:0] s;
        s = 13'(addr) << code;
        return split ? {half, s[10:0]} : s[11:0];
    endfunction : bit_base

endpackage : ram_block_pkg

// ===== src/ram_port_if.sv
// Carrier between the port control logic and the bit store.
`timescale 1ns/1ps
`default_nettype none
interface ram_port_if;
    logic [1:0] wr_go;
    logic [1:0][11:0] waddr;
    logic [1:0][31:0] wdata;
    logic [1:0][2:0] wcode;
    logic [1:0][11:0] raddr;
    logic [1:0][2:0] rcode;
    logic split;
    logic [1:0][31:0] rdata;
    modport ctrl (output wr_go, waddr, wdata, wcode, raddr, rcode, split, input rdata);
    modport store (input wr_go, waddr, wdata, wcode, raddr, rcode, split, output rdata);
endinterface : ram_port_if
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the embedded memory block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_sys_clk;
    logic i_nrst;
    logic [3:0] bus_addr;
    logic [31:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] bus_rdata;
    logic [1:0] wclk, rclk, oclk, wce, rce, clr, we, rs, rvalid;
    logic [1:0][11:0] waddr, raddr;
    logic [1:0][31:0] wdata, rdata;
    int mismatches;
    int check_count;

    embedded_memory_block u_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata), .i_bus_wr(bus_wr),
        .i_bus_rd(bus_rd), .o_bus_rdata(bus_rdata), .i_wclk(wclk), .i_rclk(rclk),
        .i_oclk(oclk), .i_wce(wce), .i_rce(rce), .i_clr(clr), .i_we(we),
        .i_waddr(waddr), .i_wdata(wdata), .i_read_strobe(rs), .i_raddr(raddr),
        .o_rdata(rdata), .o_rvalid(rvalid));

    user_fabric_model u_user (.i_sys_clk(i_sys_clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_wclk(wclk), .o_rclk(rclk), .o_oclk(oclk), .o_wce(wce), .o_rce(rce),
        .o_clr(clr), .o_we(we), .o_waddr(waddr), .o_wdata(wdata), .o_rs(rs),
        .o_raddr(raddr));

    initial
    begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge i_sys_clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge i_sys_clk);
        bus_rd <= 1'b0;
        #1;
        chk("register", bus_rdata, exp);
    endtask : bus_read

    // A latency of 20 stands for a read that must be refused.
    task automatic rdx(input int p, input logic [11:0] a, input int gap, input int lat,
        input logic [31:0] exp);
        logic [31:0] d;
        int n;
        u_user.rd(p, a, gap, d, n);
        chk("read latency", 32'(n), 32'(lat));
        chk("read data", d, exp);
        if (lat != 20 && n == 20)
            print_verdict();
    endtask : rdx

    task automatic t_reset;
        bus_read(4'h0, 32'h0000_0000);
        bus_read(4'h4, 32'h0000_0000);
        bus_read(4'h8, 32'h0000_0000);
        bus_write(4'hC, 32'hFFFF_FFFF);
        bus_read(4'hC, 32'h0000_0000);
        $display("done reset");
    endtask : t_reset

    task automatic t_quad;
        bus_write(4'h4, 32'h0000_1243);
        fork
            u_user.wr(0, 12'h002, 32'h0000_00A5);
            u_user.wr(1, 12'h010, 32'h0000_0009);
        join
        u_user.wr(0, 12'h003, 32'h0000_003C);
        fork
            rdx(0, 12'h001, 0, 2, 32'h0000_3CA5);
            rdx(1, 12'h021, 0, 2, 32'h0000_0002);
        join
        rdx(1, 12'h020, 0, 2, 32'h0000_0001);
        $display("done quad");
    endtask : t_quad

    task automatic t_outreg;
        bus_write(4'h0, 32'h0000_0040);
        rdx(0, 12'h001, 0, 3, 32'h0000_3CA5);
        rdx(0, 12'h001, 3, 5, 32'h0000_3CA5);
        rdx(1, 12'h020, 0, 2, 32'h0000_0001);
        $display("done outreg");
    endtask : t_outreg

    task automatic t_ioclk;
        bus_write(4'h0, 32'h0000_0020);
        @(posedge i_sys_clk);
        u_user.o_wclk <= 2'h2;
        rdx(0, 12'h001, 0, 20, 32'h0000_0000);
        @(posedge i_sys_clk);
        u_user.o_wclk <= 2'h3;
        rdx(0, 12'h001, 0, 2, 32'h0000_3CA5);
        bus_write(4'h0, 32'h0000_0060);
        rdx(0, 12'h001, 0, 3, 32'h0000_3CA5);
        $display("done ioclk");
    endtask : t_ioclk

    task automatic t_single;
        bus_write(4'h0, 32'h0000_0003);
        fork
            u_user.wr(0, 12'h002, 32'h0000_0077);
            rdx(0, 12'h001, 0, 20, 32'h0000_0000);
        join
        bus_read(4'h8, 32'h0000_0002);
        bus_write(4'h8, 32'h0000_0002);
        bus_read(4'h8, 32'h0000_0000);
        rdx(0, 12'h001, 0, 2, 32'h0000_3C77);
        $display("done single");
    endtask : t_single

    task automatic t_tdual;
        bus_write(4'h0, 32'h0000_0001);
        fork
            u_user.wr(0, 12'h004, 32'h0000_0055);
            rdx(1, 12'h020, 0, 2, 32'h0000_0001);
        join
        bus_read(4'h8, 32'h0000_0000);
        fork
            u_user.wr(0, 12'h005, 32'h0000_0066);
            u_user.wr(1, 12'h040, 32'h0000_0003);
        join
        rdx(0, 12'h002, 0, 2, 32'h0000_6655);
        rdx(1, 12'h080, 0, 2, 32'h0000_0003);
        $display("done tdual");
    endtask : t_tdual

    task automatic t_split;
        bus_write(4'h4, 32'h0000_5555);
        bus_write(4'h0, 32'h0000_001A);
        bus_read(4'h8, 32'h0000_0000);
        fork
            u_user.wr(0, 12'h000, 32'h1234_5678);
            u_user.wr(1, 12'h000, 32'h9ABC_DEF0);
        join
        fork
            rdx(0, 12'h000, 0, 2, 32'h1234_5678);
            rdx(1, 12'h000, 0, 2, 32'h9ABC_DEF0);
        join
        fork
            u_user.wr(0, 12'h001, 32'h0BAD_F00D);
            rdx(0, 12'h000, 0, 2, 32'h1234_5678);
        join
        bus_write(4'h4, 32'h0000_5550);
        bus_read(4'h8, 32'h0000_0001);
        bus_write(4'h0, 32'h0000_0000);
        bus_read(4'h8, 32'h0000_0001);
        bus_write(4'h4, 32'h0000_1243);
        $display("done split");
    endtask : t_split

    task automatic t_clear;
        @(posedge i_sys_clk);
        u_user.o_clr <= 2'h1;
        rdx(0, 12'h001, 0, 20, 32'h0000_0000);
        #1;
        chk("port A data", rdata[0], 32'h0000_0000);
        chk("port B data", rdata[1], 32'h9ABC_DEF0);
        @(posedge i_sys_clk);
        u_user.o_clr <= 2'h0;
        $display("done clear");
    endtask : t_clear

    task automatic t_four;
        fork
            u_user.wr(0, 12'h010, 32'h0000_00C3);
            u_user.wr(1, 12'h030, 32'h0000_0006);
            rdx(0, 12'h001, 0, 2, 32'h0000_1234);
            rdx(1, 12'h020, 0, 2, 32'h0000_0001);
        join
        bus_write(4'h0, 32'h0000_0002);
        fork
            u_user.wr(0, 12'h011, 32'h0000_005A);
            u_user.wr(1, 12'h030, 32'h0000_0009);
            rdx(0, 12'h001, 0, 2, 32'h0000_1234);
        join
        rdx(1, 12'h020, 0, 20, 32'h0000_0000);
        bus_write(4'h0, 32'h0000_0000);
        @(posedge i_sys_clk);
        u_user.o_wce <= 2'h2;
        u_user.wr(0, 12'h010, 32'h0000_00FF);
        u_user.o_wce <= 2'h3;
        rdx(0, 12'h008, 0, 2, 32'h0000_5AC3);
        rdx(1, 12'h060, 0, 2, 32'h0000_0002);
        $display("done four");
    endtask : t_four

    initial
    begin
        mismatches = 0;
        check_count = 0;
        i_nrst = 1'b0;
        bus_addr = 4'h0;
        bus_wdata = 32'h0000_0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        @(posedge i_sys_clk);
        t_reset();
        t_quad();
        t_outreg();
        t_ioclk();
        t_single();
        t_tdual();
        t_split();
        t_clear();
        t_four();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

// ===== verif/user_fabric_model.sv
// Model of the user logic that drives both memory ports.
`timescale 1ns/1ps
`default_nettype none
module user_fabric_model (
    input wire logic i_sys_clk,
    input wire logic [1:0] i_rvalid,
    input wire logic [1:0][31:0] i_rdata,
    output logic [1:0] o_wclk,
    output logic [1:0] o_rclk,
    output logic [1:0] o_oclk,
    output logic [1:0] o_wce,
    output logic [1:0] o_rce,
    output logic [1:0] o_clr,
    output logic [1:0] o_we,
    output logic [1:0][11:0] o_waddr,
    output logic [1:0][31:0] o_wdata,
    output logic [1:0] o_rs,
    output logic [1:0][11:0] o_raddr
);
    initial
    begin
        o_wclk = 2'h3;
        o_rclk = 2'h3;
        o_oclk = 2'h3;
        o_wce = 2'h3;
        o_rce = 2'h3;
        o_clr = 2'h0;
        o_we = 2'h0;
        o_rs = 2'h0;
        o_waddr = '0;
        o_wdata = '0;
        o_raddr = '0;
    end

    // Released lines carry the inverse so a stale address is never mistaken for a held one.
    task automatic wr(input int p, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        o_we[p] <= 1'b1;
        o_waddr[p] <= a;
        o_wdata[p] <= d;
        @(posedge i_sys_clk);
        o_we[p] <= 1'b0;
        o_waddr[p] <= ~a;
        o_wdata[p] <= ~d;
    endtask : wr

    // A nonzero gap holds the read clock low to model a slow output stage.
    task automatic rd(input int p, input logic [11:0] a, input int gap,
        output logic [31:0] d, output int n);
        @(posedge i_sys_clk);
        o_rs[p] <= 1'b1;
        o_raddr[p] <= a;
        @(posedge i_sys_clk);
        o_rs[p] <= 1'b0;
        o_raddr[p] <= ~a;
        if (gap > 0)
            o_rclk[p] <= 1'b0;
        d = 32'h0000_0000;
        for (n = 1; n < 20; n++)
        begin
            #1;
            if (i_rvalid[p] === 1'b1)
            begin
                d = i_rdata[p];
                break;
            end
            @(posedge i_sys_clk);
            if (n == gap)
                o_rclk[p] <= 1'b1;
        end
    endtask : rd
endmodule : user_fabric_model
`default_nettype wire
